/* src/nand_host_ctrl.sv */
// AHB-Lite controlled host that drives a byte-wide flash through its pins
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_regs.svh"

module nand_host_ctrl import nand_host_pkg::*; (
	input wire logic sys_clk_in, // System clock, 100 MHz
	input wire logic nrst_in, // Asynchronous reset, active low
	input wire logic hsel_in, // AHB slave select
	input wire logic [31:0] haddr_in, // AHB address
	input wire logic [1:0] htrans_in, // AHB transfer type
	input wire logic hwrite_in, // AHB write
	input wire logic [2:0] hsize_in, // AHB size, word only
	input wire logic [31:0] hwdata_in, // AHB write data
	input wire logic hready_in, // AHB bus ready
	output logic hreadyout_out, // AHB slave ready
	output logic hresp_out, // AHB response, always OKAY
	output logic [31:0] hrdata_out, // AHB read data
	output logic cle_out, // Command latch enable
	output logic ale_out, // Address latch enable
	output logic ce_n_out, // Chip enable, active low
	output logic we_n_out, // Write strobe, active low
	output logic output_strobe_n_out, // Read strobe, active low
	output logic [7:0] byte_port_out, // Byte port drive value
	output logic byte_port_oe_out, // Byte port drive enable
	input wire logic [7:0] byte_port_in, // Byte port level
	input wire logic ready_busy_n_in, // Ready/busy line, low busy
	output logic write_protect_n_out // Write protect, active low
);

	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ISSUE = 2'b01,
		M_WAIT = 2'b11,
		M_DONE = 2'b10
	} main_state_type;

	logic rst_meta_r, rst_n_r;
	logic rb_meta_r, rb_sync_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	main_state_type mst_r;
	op_type op_r;
	logic [7:0] byte_r;
	logic [2:0] step_r;
	logic [7:0] id_r [0:4];
	logic [7:0] stat_r, rdata_r, last_cmd_r;
	logic refused_r, serial_r, wp_n_r, ord_valid_r;
	logic [1:0] addr_cnt_r;
	logic [15:0] page_r;
	logic [9:0] last_blk_r;
	logic [5:0] last_idx_r;
	logic dev_busy, ctrl_wr, ok, accept, refuse, order_bad, cyc_done;
	op_type op_w;
	logic [7:0] code_w, cyc_rdata;
	cyc_req_type cur_req;
	nand_pins_type pins;

	// Defined command set
	function automatic logic legal_cmd(input logic [7:0] c);
		case (c)
			`CMD_SERIAL_IN, `CMD_PROGRAM, `CMD_READ_ADDR, `CMD_COL_CHANGE,
			`CMD_READ_START, `CMD_READ_COL, `CMD_ERASE, `CMD_ERASE_GO,
			`CMD_ID, `CMD_STATUS, `CMD_RESET: legal_cmd = 1'b1;
			default: legal_cmd = 1'b0;
		endcase
	endfunction : legal_cmd

	// Pin cycle for each step of an operation
	function automatic cyc_req_type cycle_for(input op_type op,
		input logic [2:0] step, input logic [7:0] b);
		case (op)
			OP_RESET: cycle_for = '{kind: K_CMD, data: `CMD_RESET};
			OP_STATUS: cycle_for = (step == 3'h0) ?
				'{kind: K_CMD, data: `CMD_STATUS} : '{kind: K_RD, data: 8'h00};
			OP_ID: begin
				if (step == 3'h0) begin
					cycle_for = '{kind: K_CMD, data: `CMD_ID}; // RQ21
				end else if (step == 3'h1) begin
					cycle_for = '{kind: K_ADDR, data: `ID_ADDR}; // RQ21
				end else begin
					cycle_for = '{kind: K_RD, data: 8'h00}; // RQ21
				end
			end
			OP_CMD: cycle_for = '{kind: K_CMD, data: b};
			OP_ADDR: cycle_for = '{kind: K_ADDR, data: b};
			OP_WDATA: cycle_for = '{kind: K_WR, data: b};
			default: cycle_for = '{kind: K_RD, data: 8'h00};
		endcase
	endfunction : cycle_for

	// Last step index of an operation
	function automatic logic [2:0] last_step(input op_type op);
		case (op)
			OP_STATUS: last_step = 3'h1;
			OP_ID: last_step = `ID_LAST_STEP;
			default: last_step = 3'h0;
		endcase
	endfunction : last_step

	// --------------------------------------------------------------
	// Reset release and pin synchroniser
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r <= rst_meta_r;
		end
	end

	// Busy assumed until the line is seen high
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			rb_meta_r <= 1'b0;
			rb_sync_r <= 1'b0;
		end else begin
			rb_meta_r <= ready_busy_n_in;
			rb_sync_r <= rb_meta_r;
		end
	end
	assign dev_busy = !rb_sync_r;

	// --------------------------------------------------------------
	// AHB-Lite slave
	// --------------------------------------------------------------
	assign hreadyout_out = 1'b1;
	assign hresp_out = 1'b0;

	// Address phase capture and read data
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_out <= 32'h0000_0000;
		end else if (hready_in) begin
			wr_pend_r <= hsel_in && htrans_in[1] && hwrite_in;
			wr_addr_r <= haddr_in[7:0];
			hrdata_out <= 32'h0000_0000;
			if (hsel_in && htrans_in[1] && !hwrite_in) begin
				case (haddr_in[7:0])
					`STAT_OFS: hrdata_out <= {16'h0000, stat_r, 1'b0,
						~stat_r[`SB_NOT_PROT] & stat_r[`SB_READY],
						stat_r[`SB_FAIL] & stat_r[`SB_READY], // RQ7
						stat_r[`SB_READY], serial_r, rb_sync_r, // RQ18
						refused_r, mst_r != M_IDLE};
					`ID_LO_OFS: hrdata_out <= {id_r[3], id_r[2], id_r[1], id_r[0]};
					`ID_HI_OFS: hrdata_out <= {24'h00_0000, id_r[4]};
					`RDATA_OFS: hrdata_out <= {24'h00_0000, rdata_r};
					`WP_OFS: hrdata_out <= {31'h0000_0000, wp_n_r};
					default: hrdata_out <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign ctrl_wr = wr_pend_r && (wr_addr_r == `CTRL_OFS);
	assign op_w = op_type'(hwdata_in[`CTRL_OP_LSB +: 3]);
	assign code_w = hwdata_in[`CTRL_BYTE_LSB +: 8];
	assign order_bad = ord_valid_r && (page_r[15:6] == last_blk_r) &&
		(page_r[5:0] <= last_idx_r);

	// Order check against the device's command restrictions
	always_comb begin
		ok = (mst_r == M_IDLE);
		case (op_w)
			OP_RESET, OP_STATUS: begin
			end
			OP_CMD: begin
				if (!legal_cmd(code_w)) ok = 1'b0; // RQ10
				if (dev_busy && code_w != `CMD_STATUS && code_w != `CMD_RESET)
					ok = 1'b0; // RQ11 RQ9
				if (serial_r && code_w != `CMD_PROGRAM && code_w != `CMD_RESET)
					ok = 1'b0; // RQ12
				if (code_w == `CMD_PROGRAM && order_bad) ok = 1'b0; // RQ14
			end
			OP_ID: begin
				if (dev_busy || serial_r) ok = 1'b0; // RQ11 RQ12
			end
			OP_ADDR, OP_WDATA: begin
				if (dev_busy) ok = 1'b0; // RQ11
			end
			OP_RDATA: begin
				if (dev_busy && last_cmd_r != `CMD_STATUS) ok = 1'b0; // RQ9
			end
			default: ok = 1'b0;
		endcase
	end
	assign accept = ctrl_wr && ok;
	assign refuse = ctrl_wr && !ok;

	// Refusal flag, cleared by the next accepted order
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			refused_r <= 1'b0;
		end else if (refuse) begin
			refused_r <= 1'b1;
		end else if (accept) begin
			refused_r <= 1'b0;
		end
	end

	// Write protect drive
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			wp_n_r <= `WP_RESET;
		end else if (wr_pend_r && wr_addr_r == `WP_OFS) begin
			wp_n_r <= hwdata_in[0];
		end
	end

	// --------------------------------------------------------------
	// Operation sequencer
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mst_r <= M_IDLE;
			op_r <= OP_RESET;
			byte_r <= 8'h00;
			step_r <= 3'h0;
		end else begin
			case (mst_r)
				M_IDLE: begin
					if (accept) begin
						op_r <= op_w;
						byte_r <= code_w;
						step_r <= 3'h0;
						mst_r <= M_ISSUE;
					end
				end
				M_ISSUE: mst_r <= M_WAIT;
				M_WAIT: begin
					if (cyc_done) begin
						if (step_r == last_step(op_r)) begin
							mst_r <= M_DONE;
						end else begin
							step_r <= step_r + 3'h1;
							mst_r <= M_ISSUE;
						end
					end
				end
				M_DONE: mst_r <= M_IDLE;
				default: mst_r <= M_IDLE;
			endcase
		end
	end
	assign cur_req = cycle_for(op_r, step_r, byte_r);

	// Read bytes stored by operation
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int i = 0; i < 5; i++) id_r[i] <= 8'h00;
			stat_r <= 8'h00;
			rdata_r <= 8'h00;
		end else if (mst_r == M_WAIT && cyc_done && cur_req.kind == K_RD) begin
			case (op_r)
				OP_ID: id_r[3'(step_r - 3'h2)] <= cyc_rdata; // RQ21
				OP_STATUS: stat_r <= cyc_rdata; // RQ18
				default: begin
					rdata_r <= cyc_rdata;
					if (last_cmd_r == `CMD_STATUS) stat_r <= cyc_rdata;
				end
			endcase
		end
	end

	// Serial input and page order tracking
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			last_cmd_r <= `CMD_RESET;
			serial_r <= 1'b0;
			addr_cnt_r <= 2'h0;
			page_r <= 16'h0000;
			ord_valid_r <= 1'b0;
			last_blk_r <= 10'h000;
			last_idx_r <= 6'h00;
		end else if (accept) begin
			case (op_w)
				OP_RESET: begin
					last_cmd_r <= `CMD_RESET;
					serial_r <= 1'b0;
				end
				OP_STATUS: last_cmd_r <= `CMD_STATUS;
				OP_ID: last_cmd_r <= `CMD_ID;
				OP_CMD: begin
					last_cmd_r <= code_w;
					serial_r <= (code_w == `CMD_SERIAL_IN); // RQ12
					addr_cnt_r <= 2'h0;
					if (code_w == `CMD_PROGRAM) begin
						ord_valid_r <= 1'b1; // RQ14
						last_blk_r <= page_r[15:6];
						last_idx_r <= page_r[5:0];
					end
					if (code_w == `CMD_ERASE) ord_valid_r <= 1'b0;
				end
				OP_ADDR: begin
					if (serial_r) begin
						addr_cnt_r <= addr_cnt_r + 2'h1;
						if (addr_cnt_r == 2'h2) page_r[7:0] <= code_w;
						if (addr_cnt_r == 2'h3) page_r[15:8] <= code_w;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// --------------------------------------------------------------
	// Pin cycle engine and pin outputs
	// --------------------------------------------------------------
	nand_strobe_cycle u_cycle (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_r),
		.start_in(mst_r == M_ISSUE),
		.req_in(cur_req),
		.io_in(byte_port_in),
		.done_out(cyc_done),
		.rdata_out(cyc_rdata),
		.pins_out(pins)
	);

	// Chip enable held across every cycle of one operation
	always_ff @(posedge sys_clk_in or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ce_n_out <= 1'b1;
		end else begin
			ce_n_out <= (mst_r == M_IDLE);
		end
	end

	assign cle_out = pins.cle;
	assign ale_out = pins.ale;
	assign we_n_out = pins.we_n;
	assign output_strobe_n_out = pins.rd_n;
	assign byte_port_out = pins.dout;
	assign byte_port_oe_out = pins.oe;
	assign write_protect_n_out = wp_n_r;

endmodule : nand_host_ctrl
`default_nettype wire

/* src/nand_host_pkg.sv */
// Types shared by the host controller and its strobe engine
package nand_host_pkg;

	typedef enum logic [1:0] {
		K_CMD = 2'h0,
		K_ADDR = 2'h1,
		K_WR = 2'h2,
		K_RD = 2'h3
	} cyc_kind_type;

	typedef enum logic [2:0] {
		OP_RESET = 3'h0,
		OP_STATUS = 3'h1,
		OP_ID = 3'h2,
		OP_CMD = 3'h3,
		OP_ADDR = 3'h4,
		OP_WDATA = 3'h5,
		OP_RDATA = 3'h6
	} op_type;

	typedef struct packed {
		cyc_kind_type kind;
		logic [7:0] data;
	} cyc_req_type;

	typedef struct packed {
		logic cle;
		logic ale;
		logic we_n;
		logic rd_n;
		logic oe;
		logic [7:0] dout;
	} nand_pins_type;

endpackage : nand_host_pkg

/* src/nand_host_regs.svh */
// Offsets, field positions, command codes and timing counts of the host
// ----------------------------------------------------------------------
// What the document requires of the device and of this host
// RQ1 - Device returns five ID bytes in order, one per output strobe.
// RQ2 - Third ID byte encodes chips, cell levels, pages; reads 80h or 00h.
// RQ3 - Fourth ID byte encodes page, spare, block size, width; 95h or 15h.
// RQ4 - Fifth ID byte encodes plane count and size; reads 40h or C0h.
// RQ5 - After status command device drives status byte on each strobe.
// RQ6 - Status bit 0 fail, bit 5 ready, bit 7 not protected.
// RQ7 - Host trusts the pass/fail bit only when status shows ready.
// RQ8 - Reset command aborts read, program or erase and idles the device.
// RQ9 - Device busy during power-on; host sends only reset or status then.
// RQ10 - Host never sends a command code outside the defined set.
// RQ11 - While busy host sends only status or reset commands.
// RQ12 - After serial input command host sends only program or reset; an OP_STATUS order is still accepted and sends 70h.
// RQ13 - Other command after serial input skips program, enters new mode.
// RQ14 - Host programs pages of one block in strictly ascending order.
// RQ15 - Status mode during array read keeps returning status bytes.
// RQ16 - Read address command in status mode resumes array output.
// RQ17 - Write protect low aborts and inhibits program and erase.
// RQ18 - Host uses status command to find which device is busy or failed.
// RQ19 - Each output strobe fall presents next byte, advances column.
// RQ20 - Device pulls ready/busy low while busy, releases when done.
// RQ21 - Host reads ID by command, one zero address, five strobes.
// RQ22 - Status after a finished reset shows ready and pass.
// ----------------------------------------------------------------------
`ifndef NAND_HOST_REGS_SVH
`define NAND_HOST_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define ID_LO_OFS 8'h08
`define ID_HI_OFS 8'h0C
`define RDATA_OFS 8'h10
`define WP_OFS 8'h14

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_OP_LSB 0
`define CTRL_BYTE_LSB 8
`define STAT_ENG_BUSY 0
`define STAT_REFUSED 1
`define STAT_DEV_READY 2
`define STAT_SERIAL 3
`define STAT_PF_VALID 4
`define STAT_FAIL 5
`define STAT_PROT 6
`define STAT_BYTE_LSB 8
`define SB_FAIL 0
`define SB_READY 5
`define SB_NOT_PROT 7
`define WP_RESET 1'b0

// ----------------------------------------------------------------------
// Device command codes
// ----------------------------------------------------------------------
`define CMD_SERIAL_IN 8'h80
`define CMD_PROGRAM 8'h10
`define CMD_READ_ADDR 8'h00
`define CMD_COL_CHANGE 8'h05
`define CMD_READ_START 8'h30
`define CMD_READ_COL 8'hE0
`define CMD_ERASE 8'h60
`define CMD_ERASE_GO 8'hD0
`define CMD_ID 8'h90
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hFF
`define ID_ADDR 8'h00
`define ID_LAST_STEP 3'h6

// ----------------------------------------------------------------------
// Strobe timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define SETUP_NS 20
`define LOW_NS 60
`define HIGH_NS 30
`define SETUP_CYC ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_CYC ((`LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HIGH_CYC ((`HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* src/nand_strobe_cycle.sv */
// One command, address, write or read cycle on the flash pins
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_regs.svh"

module nand_strobe_cycle import nand_host_pkg::*; (
	input wire logic sys_clk_in, // System clock
	input wire logic rst_n_in, // Synchronised reset, active low
	input wire logic start_in, // Start one cycle
	input wire cyc_req_type req_in, // Cycle kind and byte
	input wire logic [7:0] io_in, // Byte port from pins
	output logic done_out, // Last cycle of the transfer
	output logic [7:0] rdata_out, // Byte caught on a read
	output nand_pins_type pins_out // Strobes and byte drive
);

	typedef enum logic [1:0] {
		C_IDLE = 2'b00,
		C_SETUP = 2'b01,
		C_LOW = 2'b11,
		C_HIGH = 2'b10
	} cyc_state_type;

	cyc_state_type cst_r;
	logic [3:0] cnt_r;
	cyc_req_type req_r;
	logic [7:0] io_meta_r;
	logic [7:0] io_sync_r;
	logic setup_end;
	logic low_end;
	logic high_end;

	assign setup_end = (cnt_r == 4'(`SETUP_CYC - 1));
	assign low_end = (cnt_r == 4'(`LOW_CYC - 1));
	assign high_end = (cnt_r == 4'(`HIGH_CYC - 1));
	assign done_out = (cst_r == C_HIGH) && high_end;

	// --------------------------------------------------------------
	// Pin input synchroniser
	// --------------------------------------------------------------
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			io_meta_r <= 8'h00;
			io_sync_r <= 8'h00;
		end else begin
			io_meta_r <= io_in;
			io_sync_r <= io_meta_r;
		end
	end

	// Phase sequence: setup, strobe low, strobe high
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cst_r <= C_IDLE;
			cnt_r <= 4'h0;
			req_r <= '0;
		end else begin
			cnt_r <= cnt_r + 4'h1;
			case (cst_r)
				C_IDLE: begin
					cnt_r <= 4'h0;
					if (start_in) begin
						req_r <= req_in;
						cst_r <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (setup_end) begin
						cst_r <= C_LOW;
						cnt_r <= 4'h0;
					end
				end
				C_LOW: begin
					if (low_end) begin
						cst_r <= C_HIGH;
						cnt_r <= 4'h0;
					end
				end
				C_HIGH: begin
					if (high_end) begin
						cst_r <= C_IDLE;
						cnt_r <= 4'h0;
					end
				end
				default: begin
					cst_r <= C_IDLE;
				end
			endcase
		end
	end

	// Read byte caught just before the output strobe rises
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rdata_out <= 8'h00;
		end else if (cst_r == C_LOW && low_end && req_r.kind == K_RD) begin
			rdata_out <= io_sync_r; // RQ19
		end
	end

	// Registered pin levels, one cycle behind the phase
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pins_out <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, rd_n: 1'b1,
				oe: 1'b0, dout: 8'h00};
		end else begin
			pins_out.cle <= (cst_r != C_IDLE) && (req_r.kind == K_CMD);
			pins_out.ale <= (cst_r != C_IDLE) && (req_r.kind == K_ADDR);
			pins_out.we_n <= !((cst_r == C_LOW) && (req_r.kind != K_RD));
			pins_out.rd_n <= !((cst_r == C_LOW) && (req_r.kind == K_RD));
			pins_out.oe <= (cst_r != C_IDLE) && (req_r.kind != K_RD);
			pins_out.dout <= req_r.data;
		end
	end

endmodule : nand_strobe_cycle
`default_nettype wire

/* testbench/nand_dev_model.sv */
// Behavioural byte-wide flash answering the host's strobes
`timescale 1ns/10ps
`default_nettype none

module nand_dev_model #(
	parameter logic [7:0] MAKER_ID = 8'hA5, // Arbitrary value
	parameter logic [7:0] DEVICE_ID = 8'h3C, // Arbitrary value
	parameter int POWER_NS = 3000, // Power-on busy span
	parameter int RST_NS = 500, // Reset busy span
	parameter int PROG_NS = 3000 // Program and fetch busy span
) (
	input wire logic cle_in, // Command latch
	input wire logic ale_in, // Address latch
	input wire logic ce_n_in, // Chip enable
	input wire logic we_n_in, // Write strobe
	input wire logic output_strobe_n_in, // Read strobe
	input wire logic write_protect_n_in, // Write protect
	input wire logic host_oe_in, // Host drives port
	input wire logic [7:0] host_byte_in, // Host byte
	output logic [7:0] byte_port_out, // Resolved port level
	output logic ready_busy_n_out // Wired line level
);
	realtime busy_end = POWER_NS;
	logic busy = 1'b1, fail = 1'b0, drv = 1'b0, serial = 1'b0, armed = 1'b0;
	logic [7:0] q = 8'h00, last = 8'h00;
	logic [11:0] col = 12'h000;
	int mode = 0, idx = 0, acnt = 0;
	// Busy span tracking; line pulled up when released
	always #5 busy = ($realtime < busy_end);
	assign ready_busy_n_out = ~busy;
	// Commands and addresses on the write strobe rise
	always @(posedge we_n_in) begin
		if (!ce_n_in && cle_in) begin
			if (host_byte_in != 8'h10 && host_byte_in != 8'hFF) serial = 1'b0;
			case (host_byte_in)
			8'hFF: begin
				busy_end = $realtime + RST_NS;
				{fail, serial, armed} = 3'h0;
				mode = 0;
			end
			8'h70: mode = 1;
			8'h90: {mode, idx} = {32'd2, 32'd0};
			8'h80: serial = 1'b1;
			8'h10: begin
				if (serial && write_protect_n_in) busy_end = $realtime + PROG_NS;
				serial = 1'b0;
			end
			8'h30: begin
				busy_end = $realtime + PROG_NS;
				{armed, mode} = {1'b1, 32'd3};
			end
			8'h00: if (mode == 1 && armed) mode = 3; else acnt = 0;
			default: ;
			endcase
		end else if (!ce_n_in && ale_in) begin
			if (acnt == 0) col[7:0] = host_byte_in;
			if (acnt == 1) col[11:8] = host_byte_in[3:0];
			acnt++;
		end
	end
	// Next byte on each read strobe fall
	always @(negedge output_strobe_n_in) begin
		if (!ce_n_in) begin
			if (mode == 1) q = {write_protect_n_in, 1'b0, ~busy, 4'h0, fail};
			else if (mode == 2) q = idx == 0 ? MAKER_ID : idx == 1 ? DEVICE_ID :
				idx == 2 ? 8'h80 : idx == 3 ? 8'h95 : 8'h40;
			else q = col[7:0] ^ 8'h5A;
			if (mode == 3) col++;
			idx++;
			drv = 1'b1;
		end
	end
	// Release: the port shows the inverse of the last byte
	always @(posedge output_strobe_n_in) {drv, last} = {1'b0, q};
	assign byte_port_out = host_oe_in ? host_byte_in : drv ? q : ~last;
endmodule : nand_dev_model
`default_nettype wire

/* testbench/nand_host_ctrl_properties.sv */
// Assertions on the host's flash strobes and bus answers
`timescale 1ns/10ps
`default_nettype none

module nand_host_ctrl_checker (
	input wire logic sys_clk_in, // Clock
	input wire logic nrst_in, // Reset, active low
	input wire logic hreadyout_out, // Slave ready
	input wire logic hresp_out, // Response
	input wire logic cle_out, // Command latch
	input wire logic ale_out, // Address latch
	input wire logic ce_n_out, // Chip enable
	input wire logic we_n_out, // Write strobe
	input wire logic output_strobe_n_out, // Read strobe
	input wire logic [7:0] byte_port_out, // Byte drive
	input wire logic byte_port_oe_out // Byte enable
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);
	// Strobe pulse shapes
	sequence we_pulse;
		(!we_n_out) [*6] ##1 we_n_out;
	endsequence
	sequence rd_pulse;
		(!output_strobe_n_out) [*6] ##1 output_strobe_n_out;
	endsequence
	sequence byte_held;
		(byte_port_oe_out && $stable(byte_port_out)) [*7];
	endsequence
	// Pin relations
	chk_write_width: assert property (
		$fell(we_n_out) |-> we_pulse) else $error("write strobe width");
	chk_read_width: assert property (
		$fell(output_strobe_n_out) |-> rd_pulse) else $error("read width");
	chk_byte_held: assert property (
		$fell(we_n_out) |-> byte_held) else $error("byte moved in strobe");
	chk_setup_lead: assert property (
		$fell(we_n_out) |-> $past(byte_port_oe_out, 2) && $past(byte_port_oe_out))
		else $error("byte setup too short");
	chk_cmd_latch_held: assert property (
		$fell(we_n_out) && cle_out |-> cle_out [*7])
		else $error("command latch dropped early");
	chk_latch_exclusive: assert property (
		!(cle_out && ale_out)) else $error("both latches high");
	chk_read_released: assert property (
		!output_strobe_n_out |-> !byte_port_oe_out && !cle_out && !ale_out)
		else $error("host drives during read");
	chk_strobe_select: assert property (
		!we_n_out || !output_strobe_n_out |-> !ce_n_out)
		else $error("strobe without chip enable");
	chk_strobe_recovery: assert property (
		$rose(we_n_out) |-> (we_n_out && output_strobe_n_out) [*3])
		else $error("strobe high time short");
	chk_bus_okay: assert property (
		hreadyout_out && !hresp_out) else $error("bus answer not OKAY");
endmodule : nand_host_ctrl_checker

bind nand_host_ctrl nand_host_ctrl_checker u_chk (
	.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
	.hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
	.cle_out(cle_out), .ale_out(ale_out), .ce_n_out(ce_n_out),
	.we_n_out(we_n_out), .output_strobe_n_out(output_strobe_n_out),
	.byte_port_out(byte_port_out), .byte_port_oe_out(byte_port_oe_out)
);
`default_nettype wire

/* testbench/tb.sv */
// Bench: AHB-Lite register tests of the host against a flash model
`timescale 1ns/10ps
`default_nettype none
`include "nand_host_regs.svh"

module tb import nand_host_pkg::*; ();
	localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value
	localparam logic [7:0] DEVICE = 8'h3C; // Arbitrary value
	logic sys_clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp, cle, ale, ce_n, we_n, rd_n, boe, rb_n, wp_n;
	logic [31:0] hrdata;
	logic [7:0] bout, bin;
	int mismatches = 0;
	int n_compared = 0;
	// 100 MHz clock
	always #5 sys_clk_in = ~sys_clk_in;
	nand_host_ctrl dut (
		.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hreadyout),
		.hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata),
		.cle_out(cle), .ale_out(ale), .ce_n_out(ce_n), .we_n_out(we_n),
		.output_strobe_n_out(rd_n), .byte_port_out(bout),
		.byte_port_oe_out(boe), .byte_port_in(bin),
		.ready_busy_n_in(rb_n), .write_protect_n_out(wp_n)
	);
	nand_dev_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) flash (
		.cle_in(cle), .ale_in(ale), .ce_n_in(ce_n), .we_n_in(we_n),
		.output_strobe_n_in(rd_n), .write_protect_n_in(wp_n),
		.host_oe_in(boe), .host_byte_in(bout),
		.byte_port_out(bin), .ready_busy_n_out(rb_n)
	);
	// Verdict and end of run
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Word comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One single AHB-Lite transfer
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0000_00, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge sys_clk_in);
		while (hreadyout !== 1'b1) @(posedge sys_clk_in);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk_in);
		while (hreadyout !== 1'b1) @(posedge sys_clk_in);
		r = hrdata;
	endtask : ahb
	// Masked register read against an expectation
	task automatic rd_is(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(r & m, e);
	endtask : rd_is
	// Order one operation and wait for the engine to finish
	task automatic op(input op_type o, input logic [7:0] b);
		logic [31:0] r;
		int n;
		ahb(1'b1, `CTRL_OFS, {16'h0000, b, 5'h00, o}, r);
		r = 32'h0000_0001;
		for (n = 0; n < 500 && r[0] !== 1'b0; n++) ahb(1'b0, `STAT_OFS, 0, r);
		if (r[0] !== 1'b0) mismatches++;
	endtask : op
	// Poll until the device ready line is seen high
	task automatic wait_ready();
		logic [31:0] r = 32'h0000_0000;
		int n;
		for (n = 0; n < 1000 && r[2] !== 1'b1; n++) ahb(1'b0, `STAT_OFS, 0, r);
		if (r[2] !== 1'b1) mismatches++;
	endtask : wait_ready
	// Page address cycles, data byte and program confirm
	task automatic prog(input logic [7:0] page);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, 8'h00);
		op(OP_ADDR, page);
		op(OP_ADDR, 8'h00);
		op(OP_WDATA, 8'h3C);
		op(OP_CMD, `CMD_PROGRAM);
	endtask : prog
	// Main sequence
	initial begin
		logic [31:0] r;
		repeat (10) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		rd_is(`WP_OFS, 32'h0000_0001, 32'h0000_0000);
		chk({31'h0, wp_n}, 32'h0000_0000);
		rd_is(8'h20, 32'hFFFF_FFFF, 32'h0000_0000);
		op(OP_ID, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_0002, 32'h0000_0002);
		op(OP_STATUS, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_FFFF, 32'h0000_0000);
		op(OP_RESET, 8'h00);
		wait_ready();
		op(OP_STATUS, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_FFFF, 32'h0000_2054);
		op(OP_ID, 8'h00);
		rd_is(`ID_LO_OFS, 32'hFFFF_FFFF, {16'h9580, DEVICE, MAKER});
		rd_is(`ID_HI_OFS, 32'h0000_00FF, 32'h0000_0040);
		op(OP_CMD, 8'h12);
		rd_is(`STAT_OFS, 32'h0000_0002, 32'h0000_0002);
		ahb(1'b1, `WP_OFS, 32'h0000_0001, r);
		repeat (2) @(posedge sys_clk_in);
		chk({31'h0, wp_n}, 32'h0000_0001);
		op(OP_CMD, `CMD_SERIAL_IN);
		op(OP_ID, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_000A, 32'h0000_000A);
		prog(8'h03);
		op(OP_STATUS, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_FFF7, 32'h0000_8000);
		op(OP_CMD, `CMD_READ_ADDR);
		rd_is(`STAT_OFS, 32'h0000_0002, 32'h0000_0002);
		op(OP_RESET, 8'h00);
		wait_ready();
		op(OP_STATUS, 8'h00);
		rd_is(`STAT_OFS, 32'h0000_FFFF, 32'h0000_A014);
		op(OP_CMD, `CMD_SERIAL_IN);
		prog(8'h02);
		rd_is(`STAT_OFS, 32'h0000_0002, 32'h0000_0002);
		op(OP_CMD, `CMD_RESET);
		wait_ready();
		op(OP_CMD, `CMD_READ_ADDR);
		op(OP_ADDR, 8'h02);
		repeat (3) op(OP_ADDR, 8'h00);
		op(OP_CMD, `CMD_READ_START);
		wait_ready();
		op(OP_RDATA, 8'h00);
		rd_is(`RDATA_OFS, 32'h0000_00FF, 32'h0000_0058);
		op(OP_STATUS, 8'h00);
		op(OP_RDATA, 8'h00);
		rd_is(`RDATA_OFS, 32'h0000_00FF, 32'h0000_00A0);
		op(OP_CMD, `CMD_READ_ADDR);
		op(OP_RDATA, 8'h00);
		rd_is(`RDATA_OFS, 32'h0000_00FF, 32'h0000_0059);
		print_verdict();
	end
	// Watchdog against a hang
	initial begin
		#300000;
		mismatches++;
		print_verdict();
	end
endmodule : tb
`default_nettype wire
